// *** fcs5_config_byte.sv ***
/*
  Fifth configuration/status byte of a serial flash: lock flag, dummy
  clock count, suspend flags, abort enable and aligned-address enable.
  Also derives the dummy-clock count and effective address that the
  read engine uses for the two quad continuous-read commands, and gates
  the terminate request with the abort enable.
  Assumes a command decoder that delivers bytes already assembled
  MSB first, a single-cycle strobe for each write of this byte and for
  each decoded terminate command, and suspend levels held by the
  erase and program engines for as long as they stay suspended.
  The read opcode and address must stand one cycle before the read
  engine takes read_cfg, which lags them by one clock.
*/
`timescale 1ns/1ps
module fcs5_config_byte (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire fcs5_pkg::fcs5_byte_in_t byte_in,
  input wire logic byte5_write,
  input wire logic [7:0] byte5_wdata,
  input wire logic erase_suspended,
  input wire logic program_suspended,
  input wire logic terminate_req,
  input wire fcs5_pkg::fcs5_read_ctx_t read_ctx,
  output logic [7:0] config_status_byte5,
  output logic status_write_locked,
  output logic terminate_go,
  output fcs5_pkg::fcs5_read_cfg_t read_cfg
);

  // ------------------------------------------------------------
  // Lock sequence detector
  // ------------------------------------------------------------
  logic lock_accept;

  // Watches every byte, whatever command the decoder takes it for
  fcs5_lock_seq u_lock_seq (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .byte_in(byte_in),
    .lock_accept(lock_accept)
  );

  // ------------------------------------------------------------
  // Lock flag
  // ------------------------------------------------------------
  // Only a reset clears the flag; no write path reaches it, so a
  // locked part stays locked however the host misbehaves
  logic status_lock_flag_reg;
  logic status_lock_flag_next;

  always_comb begin
    status_lock_flag_next = status_lock_flag_reg | lock_accept;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_lock_flag_reg <= fcs5_pkg::BYTE5_RESET[fcs5_pkg::LOCK_BIT];
    end else begin
      status_lock_flag_reg <= status_lock_flag_next;
    end
  end

  // ------------------------------------------------------------
  // Write data fields
  // ------------------------------------------------------------
  // Names for the fields of an incoming write
  logic write_ok;
  logic [2:0] wdata_dummy_code;
  logic wdata_abort_en;
  logic wdata_align_en;
  logic dummy_code_defined;

  always_comb begin
    // A locked device refuses every configuration write
    write_ok = byte5_write && !status_lock_flag_reg;
    wdata_dummy_code = byte5_wdata[fcs5_pkg::DUMMY_HI:fcs5_pkg::DUMMY_LO];
    wdata_abort_en = byte5_wdata[fcs5_pkg::ABORT_EN_BIT];
    wdata_align_en = byte5_wdata[fcs5_pkg::ALIGN_EN_BIT];
    // Reserved codes are refused so the count never leaves the table
    dummy_code_defined = (wdata_dummy_code <= fcs5_pkg::DUMMY_CODE_MAX);
  end

  // ------------------------------------------------------------
  // Writable fields
  // ------------------------------------------------------------
  // Bits 7, 3 and 2 are read-only, so their write data is dropped
  logic [2:0] dummy_cycle_count_reg;
  logic [2:0] dummy_cycle_count_next;
  logic abort_cmd_enable_reg;
  logic abort_cmd_enable_next;
  logic word4_align_enable_reg;
  logic word4_align_enable_next;

  always_comb begin
    dummy_cycle_count_next = dummy_cycle_count_reg;
    abort_cmd_enable_next = abort_cmd_enable_reg;
    word4_align_enable_next = word4_align_enable_reg;
    if (write_ok) begin
      if (dummy_code_defined) begin
        dummy_cycle_count_next = wdata_dummy_code;
      end
      abort_cmd_enable_next = wdata_abort_en;
      word4_align_enable_next = wdata_align_en;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dummy_cycle_count_reg <= fcs5_pkg::DUMMY_CODE_RESET;
      abort_cmd_enable_reg <= fcs5_pkg::BYTE5_RESET[fcs5_pkg::ABORT_EN_BIT];
      word4_align_enable_reg <= fcs5_pkg::BYTE5_RESET[fcs5_pkg::ALIGN_EN_BIT];
    end else begin
      dummy_cycle_count_reg <= dummy_cycle_count_next;
      abort_cmd_enable_reg <= abort_cmd_enable_next;
      word4_align_enable_reg <= word4_align_enable_next;
    end
  end

  // ------------------------------------------------------------
  // Suspend flags
  // ------------------------------------------------------------
  // Mirrors of the engines' levels: a resume clears them again
  logic erase_paused_flag_reg;
  logic erase_paused_flag_next;
  logic program_paused_flag_reg;
  logic program_paused_flag_next;

  always_comb begin
    erase_paused_flag_next = erase_suspended;
    program_paused_flag_next = program_suspended;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      erase_paused_flag_reg <= fcs5_pkg::BYTE5_RESET[fcs5_pkg::ERASE_PAUSED_BIT];
      program_paused_flag_reg <= fcs5_pkg::BYTE5_RESET[fcs5_pkg::PROG_PAUSED_BIT];
    end else begin
      erase_paused_flag_reg <= erase_paused_flag_next;
      program_paused_flag_reg <= program_paused_flag_next;
    end
  end

  // ------------------------------------------------------------
  // Terminate gate
  // ------------------------------------------------------------
  logic terminate_go_next;

  always_comb begin
    // A disabled terminate vanishes here, so the running operation
    // never learns of it
    terminate_go_next = terminate_req && abort_cmd_enable_reg;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      terminate_go <= 1'b0;
    end else begin
      terminate_go <= terminate_go_next;
    end
  end

  // ------------------------------------------------------------
  // Read settings
  // ------------------------------------------------------------
  // Settings lag read_ctx by one clock; the read engine allows for it
  logic quad_read;
  logic aligned_read;
  logic [3:0] dummy_clocks_calc;
  fcs5_pkg::fcs5_read_cfg_t read_cfg_next;

  always_comb begin
    quad_read = (read_ctx.opcode == fcs5_pkg::CMD_QUAD_CONT_READ) ||
                (read_ctx.opcode == fcs5_pkg::CMD_QUAD_ALIGNED_READ);
    aligned_read = (read_ctx.opcode == fcs5_pkg::CMD_QUAD_ALIGNED_READ);
    // Code n gives 2n+2 clocks, the mode byte's two clocks included
    dummy_clocks_calc = {dummy_cycle_count_reg, 1'b0} + fcs5_pkg::MODE_BYTE_CLOCKS;
    read_cfg_next.quad_read_cmd = quad_read;
    // Reads other than the two quad ones take no dummy clocks from here
    read_cfg_next.dummy_clocks = quad_read ? dummy_clocks_calc : 4'h0;
    read_cfg_next.eff_address = read_ctx.address;
    // Only the aligned read drops the two low address bits
    if (aligned_read && word4_align_enable_reg) begin
      read_cfg_next.eff_address[1:0] = 2'h0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      read_cfg <= '0;
    end else begin
      read_cfg <= read_cfg_next;
    end
  end

  // ------------------------------------------------------------
  // Read-back image
  // ------------------------------------------------------------
  // The decoder shifts this image out MSB first
  always_comb begin
    config_status_byte5 = {status_lock_flag_reg, dummy_cycle_count_reg, erase_paused_flag_reg,
                           program_paused_flag_reg, abort_cmd_enable_reg, word4_align_enable_reg};
    status_write_locked = status_lock_flag_reg;
  end

endmodule : fcs5_config_byte

// *** fcs5_config_byte_monitor.sv ***
/*
  Checker for the fifth config/status byte, bound to the block's ports.
  Assumes one clock domain and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module fcs5_config_byte_monitor (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire fcs5_pkg::fcs5_byte_in_t byte_in,
  input wire logic byte5_write,
  input wire logic [7:0] byte5_wdata,
  input wire logic erase_suspended,
  input wire logic program_suspended,
  input wire logic terminate_req,
  input wire fcs5_pkg::fcs5_read_ctx_t read_ctx,
  input wire logic [7:0] config_status_byte5,
  input wire logic status_write_locked,
  input wire logic terminate_go,
  input wire fcs5_pkg::fcs5_read_cfg_t read_cfg
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ----
  // Lock key: command then both keys on consecutive bytes
  // ----
  sequence key_seq;
    byte_in.byte_valid && byte_in.frame_start && byte_in.byte_data == fcs5_pkg::CMD_STATUS_LOCK
    ##1 byte_in.byte_valid && !byte_in.frame_start && byte_in.byte_data == fcs5_pkg::LOCK_KEY_FIRST
    ##1 byte_in.byte_valid && !byte_in.frame_start && byte_in.byte_data == fcs5_pkg::LOCK_KEY_SECOND;
  endsequence
  lock_set_a:
    assert property (key_seq |-> ##2 status_write_locked && config_status_byte5[7]) else $error("lock not set");
  lock_cause_a:
    assert property ($rose(status_write_locked) |-> $past(byte_in.byte_valid, 2)
      && $past(byte_in.byte_data, 2) == fcs5_pkg::LOCK_KEY_SECOND)
    else $error("lock set without key");
  lock_hold_a:
    assert property (status_write_locked |=> status_write_locked && $stable(config_status_byte5[6:4])
      && $stable(config_status_byte5[1:0])) else $error("locked byte changed");
  // ----
  // Writes, flags and read settings
  // ----
  wr_bits_a:
    assert property (byte5_write && !status_write_locked |=> config_status_byte5[1:0] == $past(byte5_wdata[1:0]))
    else $error("enable bits not written");
  wr_dummy_a:
    assert property (byte5_write && !status_write_locked && byte5_wdata[6:4] <= 3'h4
      |=> config_status_byte5[6:4] == $past(byte5_wdata[6:4])) else $error("dummy code not written");
  suspend_a:
    assert property ($past(reset_n) |-> config_status_byte5[3:2]
      == {$past(erase_suspended), $past(program_suspended)})
    else $error("suspend flags wrong");
  term_a:
    assert property (terminate_req |=> terminate_go == $past(config_status_byte5[1])) else $error("terminate wrong");
  dummy_clk_a:
    assert property ($past(reset_n) |-> read_cfg.dummy_clocks == (($past(read_ctx.opcode) == fcs5_pkg::CMD_QUAD_CONT_READ
      || $past(read_ctx.opcode) == fcs5_pkg::CMD_QUAD_ALIGNED_READ)
      ? {$past(config_status_byte5[6:4]), 1'b0} + 4'h2 : 4'h0)) else $error("dummy clocks wrong");
  align_a:
    assert property ($past(reset_n) |-> read_cfg.eff_address == {$past(read_ctx.address[23:2]),
      ($past(read_ctx.opcode) == fcs5_pkg::CMD_QUAD_ALIGNED_READ && $past(config_status_byte5[0]))
      ? 2'b00 : $past(read_ctx.address[1:0])}) else $error("address wrong");
  quad_flag_a:
    assert property ($past(reset_n) |-> read_cfg.quad_read_cmd == ($past(read_ctx.opcode) == fcs5_pkg::CMD_QUAD_CONT_READ
      || $past(read_ctx.opcode) == fcs5_pkg::CMD_QUAD_ALIGNED_READ)) else $error("quad flag wrong");
endmodule : fcs5_config_byte_monitor

bind fcs5_config_byte fcs5_config_byte_monitor fcs5_config_byte_monitor_i (.core_clk(core_clk), .reset_n(reset_n),
  .byte_in(byte_in), .byte5_write(byte5_write), .byte5_wdata(byte5_wdata), .erase_suspended(erase_suspended),
  .program_suspended(program_suspended), .terminate_req(terminate_req), .read_ctx(read_ctx),
  .config_status_byte5(config_status_byte5), .status_write_locked(status_write_locked),
  .terminate_go(terminate_go), .read_cfg(read_cfg));

// *** fcs5_host_model.sv ***
/*
  Host side model: byte stream of the command decoder and byte writes.
  Assumes the caller enters its tasks just after a rising edge.
*/
`timescale 1ns/1ps
module fcs5_host_model (
  input wire logic core_clk,
  output fcs5_pkg::fcs5_byte_in_t byte_in,
  output logic byte5_write,
  output logic [7:0] byte5_wdata
);
  initial begin
    byte_in = '0;
    byte5_write = 1'b0;
    byte5_wdata = 8'h00;
  end
  // Whole bytes, MSB-first assembled, back to back
  task automatic lock(input logic [7:0] key2);
    logic [7:0] seq [3];
    seq = '{fcs5_pkg::CMD_STATUS_LOCK, fcs5_pkg::LOCK_KEY_FIRST, key2};
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk) byte_in <= '{(i == 0), 1'b1, seq[i]};
    end
    // Released line shows a changed value, never the last byte
    @(posedge core_clk) byte_in <= '{1'b0, 1'b0, ~key2};
  endtask : lock
  // Callers keep the dummy field on defined codes except on purpose
  task automatic wr(input logic [7:0] d);
    @(posedge core_clk) byte5_write <= 1'b1;
    byte5_wdata <= d;
    @(posedge core_clk) byte5_write <= 1'b0;
    byte5_wdata <= ~d;
  endtask : wr
endmodule : fcs5_host_model

// *** fcs5_lock_seq.sv ***
/*
  Detector for the status-lock sequence; the lock it sets holds until reset.
  Assumes frame_start pulses at the start of each chip-select frame and
  byte_valid pulses once per received byte.
*/
`timescale 1ns/1ps
module fcs5_lock_seq (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire fcs5_pkg::fcs5_byte_in_t byte_in,
  output logic lock_accept
);

  fcs5_pkg::fcs5_lock_state_t state_reg;
  fcs5_pkg::fcs5_lock_state_t state_next;
  logic lock_accept_next;

  always_comb begin
    state_next = state_reg;
    lock_accept_next = 1'b0;
    if (byte_in.frame_start) begin
      // A new frame always restarts the search, whatever the old one left
      state_next = (byte_in.byte_valid && byte_in.byte_data == fcs5_pkg::CMD_STATUS_LOCK) ?
                   fcs5_pkg::LOCK_GOT_CMD : fcs5_pkg::LOCK_IDLE;
    end else if (byte_in.byte_valid) begin
      // Bytes must follow each other directly, any other byte aborts
      case (state_reg)
        fcs5_pkg::LOCK_IDLE: begin
          state_next = fcs5_pkg::LOCK_IDLE;
        end
        fcs5_pkg::LOCK_GOT_CMD: begin
          state_next = (byte_in.byte_data == fcs5_pkg::LOCK_KEY_FIRST) ?
                       fcs5_pkg::LOCK_GOT_KEY1 : fcs5_pkg::LOCK_IDLE;
        end
        fcs5_pkg::LOCK_GOT_KEY1: begin
          lock_accept_next = (byte_in.byte_data == fcs5_pkg::LOCK_KEY_SECOND);
          state_next = fcs5_pkg::LOCK_IDLE;
        end
        default: begin
          state_next = fcs5_pkg::LOCK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= fcs5_pkg::LOCK_IDLE;
      lock_accept <= 1'b0;
    end else begin
      state_reg <= state_next;
      lock_accept <= lock_accept_next;
    end
  end

endmodule : fcs5_lock_seq

// *** fcs5_pkg.sv ***
/*
  Package for the fifth configuration/status byte of a serial flash.
  Holds field positions, reset values, command codes and carrier structs.
  Assumes the command decoder hands over whole bytes, MSB-first assembled.
*/
package fcs5_pkg;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LOCK_BIT = 7;
  localparam int DUMMY_HI = 6;
  localparam int DUMMY_LO = 4;
  localparam int ERASE_PAUSED_BIT = 3;
  localparam int PROG_PAUSED_BIT = 2;
  localparam int ABORT_EN_BIT = 1;
  localparam int ALIGN_EN_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] BYTE5_RESET = 8'h00;
  localparam logic [2:0] DUMMY_CODE_RESET = 3'h0;
  localparam logic [2:0] DUMMY_CODE_MAX = 3'h4;
  // Two of the dummy clocks carry the mode byte
  localparam logic [3:0] MODE_BYTE_CLOCKS = 4'h2;

  // ----------------------------------------------------------------
  // Command and verification codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_STATUS_LOCK = 8'h6F;
  localparam logic [7:0] LOCK_KEY_FIRST = 8'h4D;
  localparam logic [7:0] LOCK_KEY_SECOND = 8'h67;
  localparam logic [7:0] CMD_QUAD_CONT_READ = 8'hEB;
  localparam logic [7:0] CMD_QUAD_ALIGNED_READ = 8'hE7;

  typedef enum logic [1:0] {
    LOCK_IDLE,
    LOCK_GOT_CMD,
    LOCK_GOT_KEY1
  } fcs5_lock_state_t;

  // Byte stream from the command decoder
  typedef struct packed {
    logic frame_start;
    logic byte_valid;
    logic [7:0] byte_data;
  } fcs5_byte_in_t;

  // Read-command context from the command decoder
  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] address;
  } fcs5_read_ctx_t;

  // Settings exported to the read engine
  typedef struct packed {
    logic quad_read_cmd;
    logic [3:0] dummy_clocks;
    logic [23:0] eff_address;
  } fcs5_read_cfg_t;

endpackage : fcs5_pkg

// *** fcs5_testbench.sv ***
/*
  Bench for the fifth config/status byte: write table, then hand tests.
  Assumes the host model drives byte stream and write strobe.
*/
`timescale 1ns/1ps
module testbench;
  typedef struct {logic [7:0] wd; logic [7:0] b; logic [3:0] dc;} fcs5_row_t;
  // Write data, byte read back, dummy clocks under the quad read; 7D is reserved
  fcs5_row_t rows [6] = '{'{8'h12, 8'h12, 4'h4}, '{8'hCB, 8'h43, 4'hA}, '{8'h7D, 8'h41, 4'hA},
    '{8'h3C, 8'h30, 4'h8}, '{8'h20, 8'h20, 4'h6}, '{8'h00, 8'h00, 4'h2}};
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic erase_suspended = 1'b0;
  logic program_suspended = 1'b0;
  logic terminate_req = 1'b0;
  fcs5_pkg::fcs5_read_ctx_t read_ctx = '0;
  fcs5_pkg::fcs5_byte_in_t byte_in;
  logic byte5_write;
  logic [7:0] byte5_wdata;
  logic [7:0] config_status_byte5;
  logic status_write_locked;
  logic terminate_go;
  fcs5_pkg::fcs5_read_cfg_t read_cfg;
  int errors = 0;
  int tests_run = 0;
  always #50 core_clk = ~core_clk;
  fcs5_host_model fcs5_host_model_i (.core_clk(core_clk), .byte_in(byte_in), .byte5_write(byte5_write),
    .byte5_wdata(byte5_wdata));
  fcs5_config_byte fcs5_config_byte_i (.core_clk(core_clk), .reset_n(reset_n), .byte_in(byte_in),
    .byte5_write(byte5_write), .byte5_wdata(byte5_wdata), .erase_suspended(erase_suspended),
    .program_suspended(program_suspended), .terminate_req(terminate_req), .read_ctx(read_ctx),
    .config_status_byte5(config_status_byte5), .status_write_locked(status_write_locked),
    .terminate_go(terminate_go), .read_cfg(read_cfg));
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic conclude;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  // Whole run is under 100 cycles; ten times that means a hang
  initial begin
    #100000;
    errors++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    read_ctx <= '{8'hEB, 24'h12_3457};
    #1 check("reset byte", config_status_byte5, 8'h00);
    for (int i = 0; i < 6; i++) begin
      fcs5_host_model_i.wr(rows[i].wd);
      #1 check("byte", config_status_byte5, rows[i].b);
      @(posedge core_clk);
      #1 check("dummy", read_cfg.dummy_clocks, rows[i].dc);
    end
    @(posedge core_clk) terminate_req <= 1'b1;
    @(posedge core_clk) terminate_req <= 1'b0;
    #1 check("terminate off", terminate_go, 1'b0);
    fcs5_host_model_i.wr(8'h03);
    @(posedge core_clk) terminate_req <= 1'b1;
    read_ctx.opcode <= 8'hE7;
    @(posedge core_clk) terminate_req <= 1'b0;
    #1 check("terminate on", terminate_go, 1'b1);
    check("aligned", read_cfg.eff_address, 24'h12_3454);
    check("quad flag", read_cfg.quad_read_cmd, 1'b1);
    // The plain quad read must keep the low address bits despite the enable
    @(posedge core_clk) read_ctx.opcode <= 8'hEB;
    @(posedge core_clk);
    #1 check("quad addr", read_cfg.eff_address, 24'h12_3457);
    @(posedge core_clk) read_ctx.opcode <= 8'h03;
    erase_suspended <= 1'b1;
    program_suspended <= 1'b1;
    @(posedge core_clk);
    #1 check("plain addr", read_cfg.eff_address, 24'h12_3457);
    check("plain dummy", read_cfg.dummy_clocks, 4'h0);
    check("plain quad", read_cfg.quad_read_cmd, 1'b0);
    check("suspend", config_status_byte5[3:2], 2'b11);
    fcs5_host_model_i.lock(8'h66);
    erase_suspended <= 1'b0;
    program_suspended <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 check("bad key", status_write_locked, 1'b0);
    check("resume", config_status_byte5[3:2], 2'b00);
    fcs5_host_model_i.lock(8'h67);
    @(posedge core_clk);
    #1 check("lock", config_status_byte5[7], 1'b1);
    fcs5_host_model_i.wr(8'h00);
    #1 check("locked byte", config_status_byte5, 8'h83);
    // Mid-run reset: lock and enables must come back cleared
    @(posedge core_clk) reset_n <= 1'b0;
    #1 check("reset lock", status_write_locked, 1'b0);
    check("reset again", config_status_byte5, 8'h00);
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk) terminate_req <= 1'b1;
    @(posedge core_clk) terminate_req <= 1'b0;
    #1 check("terminate reset", terminate_go, 1'b0);
    conclude();
  end
endmodule : testbench
